//--- hw/lsi_indicator.sv
// light screen status indicator and display logic with ahb-lite registers
// Notes on behaviour
// - emitter lamp: red flash, green, flashing.
// - emitter shows error code in lockout.
// - scan code shown briefly at start, change.
// - power-up scan code flashes three times.
// - receiver lamp green outputs on, else red.
// - lockout: flash red, lamps off, code.
// - reset lamp on, off, double, steady flash.
// - display dash for trip, L for latch.
// - eight zone lamps, each one eighth.
// - zone green clear, red blocked.
// - beam one blocked: zone one red only.
// - run clear: green, flashing reduced resolution.
// - display blocked beam count when synced.
// - latch: outputs on only run clear.
// - cascade stop brackets display with goalposts.
// - downstream blocked: outputs off, red, reset on.
// - trip auto recovers, latch needs reset.
`timescale 1ns/1ps
`include "lsi_defs.svh"
module lsi_indicator #(
	parameter int unsigned SLOW_CYC = `LSI_SLOW_CYC,
	parameter int unsigned SCAN_CYC = `LSI_SCAN_CYC,
	parameter int unsigned ZONES = `LSI_ZONES
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_b,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	// lamps and display
	output lsi_pkg::lsi_lamp_e o_emit_status,
	output lsi_pkg::lsi_seg_t o_emit_disp,
	output lsi_pkg::lsi_lamp_e o_rcv_status,
	output logic o_reset_lamp,
	output lsi_pkg::lsi_lamp_e o_zone [ZONES],
	output lsi_pkg::lsi_seg_t o_rcv_disp,
	output logic o_goal_left,
	output logic o_goal_right,
	output logic o_safety_switching_output,
	// interrupt
	output logic o_irq
);
	import lsi_pkg::*;

	typedef struct packed {
		logic [2:0] mode;
		logic latch;
		logic redres;
		logic scan;
		logic cstop;
		logic dnblk;
		logic [15:0] beams;
		logic [7:0] err;
		logic [2:0] irq;
		logic [2:0] mask;
		logic [31:0] tick;
		logic [3:0] phase;
		logic [31:0] scan_cnt;
		logic [2:0] scan_left;
		logic ph_sel;
		logic [7:0] ph_addr;
		logic ph_wr;
		logic [31:0] rdata;
		logic sw_out;
		logic [1:0] estat;
		logic [7:0] edisp;
		logic [1:0] rstat;
		logic rlamp;
		logic [2*ZONES-1:0] zones;
		logic [7:0] rdisp;
		logic goal;
		logic irq_o;
	} lsi_state_s;

	lsi_state_s st_reg, st_next;
	logic [ZONES-1:0] zone_blk;
	logic all_clear, slow, dbl, single;
	logic [7:0] nblk;

	// one digit glyph; count above nine shows nine
	function automatic lsi_seg_t lsi_digit(input logic [7:0] v);
		case (v > 8'h09 ? 8'h09 : v)
			8'h00: lsi_digit = 8'h3F;
			8'h01: lsi_digit = 8'h06;
			8'h02: lsi_digit = 8'h5B;
			8'h03: lsi_digit = 8'h4F;
			8'h04: lsi_digit = 8'h66;
			8'h05: lsi_digit = 8'h6D;
			8'h06: lsi_digit = 8'h7D;
			8'h07: lsi_digit = 8'h07;
			8'h08: lsi_digit = 8'h7F;
			default: lsi_digit = 8'h6F;
		endcase
	endfunction

	// two beams map to each zone
	genvar g;
	generate
		for (g = 0; g < ZONES; g++) begin : g_zone
			assign zone_blk[g] = |st_reg.beams[2*g +: 2];
			assign o_zone[g] = lsi_lamp_e'(st_reg.zones[2*g +: 2]);
		end
	endgenerate

	always_comb begin
		nblk = 8'h00;
		for (int i = 0; i < 16; i++) begin
			nblk = nblk + {7'h00, st_reg.beams[i]};
		end
	end
	assign all_clear = (st_reg.beams == 16'h0000);
	// phase cycles 16 slow ticks: steady flash, double flash, single flash
	assign slow = st_reg.phase[0];
	assign dbl = (st_reg.phase[3:2] == 2'b00) && st_reg.phase[0];
	assign single = (st_reg.phase[3:1] == 3'b000);

	always_comb begin
		logic wr_hit;
		logic [7:0] cnt_disp;
		lsi_mode_e m;
		wr_hit = 1'b0;
		cnt_disp = 8'h00;
		m = lsi_mode_e'(st_reg.mode);
		st_next = st_reg;
		// ahb address phase capture, zero wait states
		if (i_hready) begin
			st_next.ph_sel = i_hsel && i_htrans[1];
			st_next.ph_addr = i_haddr[7:0];
			st_next.ph_wr = i_hwrite;
		end
		wr_hit = st_reg.ph_sel && st_reg.ph_wr;
		if (wr_hit) begin
			case ({24'h00_0000, st_reg.ph_addr})
				`LSI_OFF_CTRL: begin
					st_next.mode = i_hwdata[2:0];
					st_next.latch = i_hwdata[`LSI_CTRL_LATCH];
					st_next.redres = i_hwdata[`LSI_CTRL_REDRES];
					st_next.scan = i_hwdata[`LSI_CTRL_SCAN];
					st_next.cstop = i_hwdata[`LSI_CTRL_CSTOP];
					st_next.dnblk = i_hwdata[`LSI_CTRL_DNBLK];
				end
				`LSI_OFF_BEAMS: st_next.beams = i_hwdata[15:0];
				`LSI_OFF_ERR: st_next.err = i_hwdata[7:0];
				`LSI_OFF_IRQ: st_next.irq = st_reg.irq & ~i_hwdata[2:0];
				`LSI_OFF_MASK: st_next.mask = i_hwdata[2:0];
				default: ;
			endcase
		end
		// reset request: latched-clear goes to run, lockout to alignment
		if (wr_hit && st_reg.ph_addr == `LSI_OFF_CTRL
			&& i_hwdata[`LSI_CTRL_RESET]) begin
			if (m == LSI_LATCHED && all_clear)
				st_next.mode = LSI_RUN;
			else if (m == LSI_ALIGN && st_reg.latch && all_clear)
				st_next.mode = LSI_RUN;
			else if (m == LSI_LOCK)
				st_next.mode = LSI_ALIGN;
		end
		// latch config: any blocked beam in run latches the outputs off
		if (m == LSI_RUN && st_reg.latch && !all_clear)
			st_next.mode = LSI_LATCHED;
		// trip config leaves alignment on its own when clear
		if (m == LSI_ALIGN && !st_reg.latch && all_clear)
			st_next.mode = LSI_RUN;
		// scan code shown after start or change
		if (st_reg.scan_cnt != 32'h0000_0000)
			st_next.scan_cnt = st_reg.scan_cnt - 32'h0000_0001;
		if (st_next.scan != st_reg.scan)
			st_next.scan_cnt = SCAN_CYC;
		// flash tick
		if (st_reg.tick >= SLOW_CYC - 1) begin
			st_next.tick = 32'h0000_0000;
			st_next.phase = st_reg.phase + 4'h1;
			if (m == LSI_PWR && st_reg.phase[0]) begin
				if (st_reg.scan_left > 3'h1)
					st_next.scan_left = st_reg.scan_left - 3'h1;
				else
					st_next.mode = LSI_ALIGN;
			end
		end else begin
			st_next.tick = st_reg.tick + 32'h0000_0001;
		end
		// outputs on only in run with all clear and no cascade stop
		st_next.sw_out = (m == LSI_RUN) && all_clear && !st_reg.cstop
			&& !st_reg.dnblk;
		// emitter lamp and display
		case (m)
			LSI_PWR: st_next.estat = single ? LSI_RED : LSI_OFF;
			LSI_RUN: st_next.estat = LSI_GREEN;
			LSI_TEST: st_next.estat = slow ? LSI_GREEN : LSI_OFF;
			LSI_LOCK: st_next.estat = slow ? LSI_RED : LSI_OFF;
			default: st_next.estat = LSI_GREEN;
		endcase
		if (m == LSI_LOCK)
			st_next.edisp = st_reg.err;
		else if (m == LSI_PWR)
			st_next.edisp = slow ? lsi_digit({7'h00, st_reg.scan} + 8'h01)
				: `LSI_DISP_BLANK;
		else if (st_reg.scan_cnt != 32'h0000_0000)
			st_next.edisp = lsi_digit({7'h00, st_reg.scan} + 8'h01);
		else
			st_next.edisp = `LSI_DISP_BLANK;
		// receiver status lamp
		if (m == LSI_LOCK)
			st_next.rstat = slow ? LSI_RED : LSI_OFF;
		else if (m == LSI_PWR)
			st_next.rstat = single ? LSI_RED : LSI_OFF;
		else if (st_next.sw_out)
			st_next.rstat = (st_reg.redres && !slow) ? LSI_OFF
				: LSI_GREEN;
		else
			st_next.rstat = LSI_RED;
		// reset lamp
		case (m)
			LSI_RUN: st_next.rlamp = 1'b1;
			LSI_LATCHED: st_next.rlamp = all_clear ? slow : 1'b1;
			LSI_ALIGN: st_next.rlamp = (st_reg.latch && all_clear) ? dbl
				: 1'b0;
			default: st_next.rlamp = 1'b0;
		endcase
		// zone lamps
		for (int z = 0; z < ZONES; z++) begin
			if (m == LSI_LOCK)
				st_next.zones[2*z +: 2] = LSI_OFF;
			else if (m == LSI_PWR)
				st_next.zones[2*z +: 2] = single ? LSI_RED : LSI_OFF;
			else if (st_reg.beams[0])
				st_next.zones[2*z +: 2] = (z == 0) ? LSI_RED : LSI_OFF;
			else
				st_next.zones[2*z +: 2] = zone_blk[z] ? LSI_RED
					: LSI_GREEN;
		end
		// receiver display
		cnt_disp = lsi_digit(nblk);
		if (m == LSI_LOCK)
			st_next.rdisp = st_reg.err;
		else if (m == LSI_PWR)
			st_next.rdisp = slow ? lsi_digit({7'h00, st_reg.scan} + 8'h01)
				: `LSI_DISP_BLANK;
		else if (st_reg.scan_cnt != 32'h0000_0000)
			st_next.rdisp = lsi_digit({7'h00, st_reg.scan} + 8'h01);
		else if (!all_clear && !st_reg.beams[0] && (m == LSI_ALIGN
			|| m == LSI_RUN || m == LSI_LATCHED))
			st_next.rdisp = cnt_disp;
		else
			st_next.rdisp = st_reg.latch ? `LSI_DISP_L
				: `LSI_DISP_DASH;
		st_next.goal = st_reg.cstop;
		// sticky events, set wins over clear
		if (m != LSI_LOCK && st_next.mode == LSI_LOCK)
			st_next.irq[`LSI_IRQ_LOCK] = 1'b1;
		if (st_next.scan != st_reg.scan)
			st_next.irq[`LSI_IRQ_SCAN] = 1'b1;
		if (m != LSI_LATCHED && st_next.mode == LSI_LATCHED)
			st_next.irq[`LSI_IRQ_LATCH] = 1'b1;
		st_next.irq_o = |(st_next.irq & st_next.mask);
		// read data for the next data phase
		case ({24'h00_0000, i_haddr[7:0]})
			`LSI_OFF_CTRL: st_next.rdata = {24'h00_0000, st_reg.dnblk,
				st_reg.cstop, st_reg.scan, st_reg.redres, st_reg.latch,
				st_reg.mode};
			`LSI_OFF_STAT: st_next.rdata = {28'h000_0000, st_reg.goal,
				st_reg.rlamp, st_reg.sw_out, all_clear};
			`LSI_OFF_BEAMS: st_next.rdata = {16'h0000, st_reg.beams};
			`LSI_OFF_ERR: st_next.rdata = {24'h00_0000, st_reg.err};
			`LSI_OFF_IRQ: st_next.rdata = {29'h0000_0000, st_reg.irq};
			`LSI_OFF_MASK: st_next.rdata = {29'h0000_0000, st_reg.mask};
			`LSI_OFF_LAMPS: st_next.rdata = {8'h00, st_reg.zones,
				2'b00, st_reg.rstat, 2'b00, st_reg.estat};
			`LSI_OFF_DISP: st_next.rdata = {16'h0000, st_reg.rdisp,
				st_reg.edisp};
			default: st_next.rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_b) begin
			st_reg <= '0;
			st_reg.scan_left <= 3'(`LSI_SCAN_FLASHES);
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_hrdata = st_reg.rdata;
	assign o_hreadyout = 1'b1;
	assign o_hresp = 1'b0;
	assign o_emit_status = lsi_lamp_e'(st_reg.estat);
	assign o_emit_disp = st_reg.edisp;
	assign o_rcv_status = lsi_lamp_e'(st_reg.rstat);
	assign o_reset_lamp = st_reg.rlamp;
	assign o_rcv_disp = st_reg.rdisp;
	assign o_goal_left = st_reg.goal;
	assign o_goal_right = st_reg.goal;
	assign o_safety_switching_output = st_reg.sw_out;
	assign o_irq = st_reg.irq_o;

	a_out_latch_run: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) o_safety_switching_output |-> $past(st_reg.mode) ==
		LSI_RUN && $past(all_clear)) else $error("outputs on outside run");
	a_lock_lamps_off: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) st_reg.mode == LSI_LOCK ##1 st_reg.mode == LSI_LOCK
		|-> !o_reset_lamp && o_rcv_status != LSI_GREEN)
		else $error("lockout lamps wrong");
	a_beam1_zones: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) st_reg.beams[0] && st_reg.mode inside {LSI_ALIGN,
		LSI_RUN, LSI_LATCHED} |=> o_zone[1] == LSI_OFF)
		else $error("zone two lit with beam one blocked");
	a_goal_follow: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) $rose(st_reg.cstop) |=> o_goal_left && o_goal_right)
		else $error("goalposts missing");
	a_status_green: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) o_safety_switching_output && !st_reg.redres |=>
		o_rcv_status == LSI_GREEN || !$past(st_next.sw_out))
		else $error("status not green with outputs on");
	a_run_reset_on: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) st_reg.mode == LSI_RUN |=> o_reset_lamp ||
		$past(st_reg.mode) != LSI_RUN) else $error("reset lamp off in run");
	a_lock_err: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) st_reg.mode == LSI_LOCK |=> o_rcv_disp ==
		$past(st_reg.err) && o_emit_disp == $past(st_reg.err))
		else $error("error code not shown");
	a_latch_trip: assert property (@(posedge i_sys_clk) disable iff
		(!i_rst_b) st_reg.mode == LSI_RUN && st_reg.latch && !all_clear
		|=> st_reg.mode == LSI_LATCHED) else $error("latch not taken");
endmodule

//--- hw/lsi_defs.svh
// constants of the light screen indicator logic
`ifndef LSI_DEFS_SVH
`define LSI_DEFS_SVH
`define LSI_CLK_HZ 200000000
`define LSI_SLOW_MS 250
`define LSI_SLOW_CYC ((`LSI_CLK_HZ / 1000) * `LSI_SLOW_MS)
`define LSI_SCAN_MS 2000
`define LSI_SCAN_CYC ((`LSI_CLK_HZ / 1000) * `LSI_SCAN_MS)
`define LSI_SCAN_FLASHES 3
`define LSI_ZONES 8
`define LSI_OFF_CTRL 32'h0000_0000
`define LSI_OFF_STAT 32'h0000_0004
`define LSI_OFF_BEAMS 32'h0000_0008
`define LSI_OFF_ERR 32'h0000_000C
`define LSI_OFF_IRQ 32'h0000_0010
`define LSI_OFF_MASK 32'h0000_0014
`define LSI_OFF_LAMPS 32'h0000_0018
`define LSI_OFF_DISP 32'h0000_001C
`define LSI_CTRL_MODE 0
`define LSI_CTRL_LATCH 3
`define LSI_CTRL_REDRES 4
`define LSI_CTRL_SCAN 5
`define LSI_CTRL_CSTOP 6
`define LSI_CTRL_DNBLK 7
`define LSI_CTRL_RESET 8
`define LSI_IRQ_LOCK 0
`define LSI_IRQ_SCAN 1
`define LSI_IRQ_LATCH 2
`define LSI_DISP_DASH 8'h40
`define LSI_DISP_L 8'h38
`define LSI_DISP_BLANK 8'h00
`endif

//--- hw/lsi_pkg.sv
// types of the light screen indicator logic
package lsi_pkg;
	typedef enum logic [2:0] {
		LSI_PWR, LSI_ALIGN, LSI_RUN, LSI_TEST, LSI_LATCHED, LSI_LOCK
	} lsi_mode_e;
	typedef enum logic [1:0] {
		LSI_OFF, LSI_RED, LSI_GREEN
	} lsi_lamp_e;
	typedef logic [7:0] lsi_seg_t;
endpackage

//--- sim/lsi_operator.sv
// operator model that watches the receiver lamps and display
`timescale 1ns/1ps
module lsi_operator (
	// clock and tally clear
	input wire logic i_clk,
	input wire logic i_clr,
	// what the operator sees
	input wire lsi_pkg::lsi_lamp_e i_status,
	input wire logic i_amber,
	input wire lsi_pkg::lsi_seg_t i_disp,
	// tallies
	output int o_green,
	output int o_off,
	output int o_amber_rise,
	output int o_disp_rise
);
	import lsi_pkg::*;
	logic amber_q;
	logic disp_q;
	// an eye sees flashes as rises, so amber and display rises are counted; status lamp green and off are counted as levels
	always @(posedge i_clk) begin
		amber_q <= i_amber;
		disp_q <= (i_disp != 8'h00);
		if (i_clr) begin
			o_green <= 0;
			o_off <= 0;
			o_amber_rise <= 0;
			o_disp_rise <= 0;
		end else begin
			o_green <= o_green + int'(i_status == LSI_GREEN);
			o_off <= o_off + int'(i_status == LSI_OFF);
			o_amber_rise <= o_amber_rise + int'(i_amber && !amber_q);
			o_disp_rise <= o_disp_rise + int'(i_disp != 8'h00 && !disp_q);
		end
	end
endmodule

//--- sim/lsi_indicator_tb.sv
// self-checking bench of the light screen indicator logic
`timescale 1ns/1ps
`include "lsi_defs.svh"
module lsi_indicator_tb;
	import lsi_pkg::*;
	localparam logic [31:0] LAT = 32'h0000_0008;
	localparam logic [31:0] RRS = 32'h0000_0010;
	localparam logic [31:0] SCN = 32'h0000_0020;
	localparam logic [31:0] CST = 32'h0000_0040;
	localparam logic [31:0] DNB = 32'h0000_0080;
	localparam logic [31:0] RST = 32'h0000_0100;
	localparam logic [31:0] ERR = 32'h0000_0079;
	// digit glyphs 0 to 9, segment a in bit 0
	localparam logic [7:0] SEG [10] = '{8'h3F, 8'h06, 8'h5B, 8'h4F,
		8'h66, 8'h6D, 8'h7D, 8'h07, 8'h7F, 8'h6F};
	logic clk = 0;
	logic rst_b = 0;
	logic hsel = 0;
	logic hwrite = 0;
	logic clr = 1;
	logic [1:0] htrans = 2'b00;
	logic [31:0] haddr = 32'h0000_0000;
	logic [31:0] hwdata = 32'h0000_0000;
	logic [2:0] hsize = 3'b010;
	logic [31:0] hrdata;
	logic [31:0] q;
	logic [15:0] b;
	logic hrdy;
	logic hresp;
	logic rlamp;
	logic gl;
	logic gr;
	logic safe;
	logic irq;
	lsi_lamp_e est;
	lsi_lamp_e rst_lamp;
	lsi_lamp_e zone [8];
	lsi_seg_t edisp;
	lsi_seg_t rdisp;
	int green;
	int off;
	int arise;
	int drise;
	int bad_count = 0;
	int compares = 0;
	int cycles = 0;
	int se;
	int sr;
	always #2.5 clk = ~clk;
	lsi_indicator #(.SLOW_CYC(4), .SCAN_CYC(40)) lsi_indicator_inst (
		.i_sys_clk(clk), .i_rst_b(rst_b), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hrdata(hrdata),
		.o_hreadyout(hrdy), .o_hresp(hresp), .o_emit_status(est),
		.o_emit_disp(edisp), .o_rcv_status(rst_lamp),
		.o_reset_lamp(rlamp), .o_zone(zone), .o_rcv_disp(rdisp),
		.o_goal_left(gl), .o_goal_right(gr),
		.o_safety_switching_output(safe), .o_irq(irq));
	lsi_operator lsi_operator_inst (
		.i_clk(clk), .i_clr(clr), .i_status(rst_lamp), .i_amber(rlamp),
		.i_disp(rdisp), .o_green(green), .o_off(off),
		.o_amber_rise(arise), .o_disp_rise(drise));
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task finish_test();
		$display("compares %0d bad_count %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// held until hready is seen high, as the bus requires
	task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= a;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hrdy !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
	task cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task tally(input int n);
		clr <= 1'b1;
		@(posedge clk);
		clr <= 1'b0;
		cyc(n);
	endtask
	// model: beam 1 carries sync, so zones past the first go dark
	function automatic lsi_lamp_e zexp(input logic [15:0] v, input int z);
		if (v[0])
			return (z == 0) ? LSI_RED : LSI_OFF;
		return (v[2*z +: 2] != 2'b00) ? LSI_RED : LSI_GREEN;
	endfunction
	task zones(input logic [15:0] v, input logic lock);
		for (int z = 0; z < 8; z++)
			chk(zone[z], lock ? LSI_OFF : zexp(v, z));
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			finish_test();
		end
	end
	initial begin
		void'($urandom(32'h5ca8_1425));
		cyc(16);
		chk(safe, 0);
		chk(rst_lamp, LSI_OFF);
		rst_b <= 1'b1;
		tally(1000);
		chk(drise, 3);
		$display("test power_up done");
		bus(1, `LSI_OFF_BEAMS, 0);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_RUN));
		cyc(8);
		chk(safe, 1);
		chk(rst_lamp, LSI_GREEN);
		chk(rlamp, 1);
		chk(rdisp, `LSI_DISP_DASH);
		chk(est, LSI_GREEN);
		zones(0, 0);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_RUN) | RRS);
		tally(64);
		chk(green > 0 && off > 0, 1);
		$display("test run_trip done");
		for (int i = 0; i < 6; i++) begin
			b = 16'($urandom);
			b[1] = 1'b1;
			b[0] = i[0];
			bus(1, `LSI_OFF_BEAMS, 32'(b));
			cyc(4);
			zones(b, 0);
			chk(safe, 0);
			chk(rst_lamp, LSI_RED);
			sr = ($countones(b) > 9) ? 9 : $countones(b);
			if (!b[0])
				chk(rdisp, SEG[sr]);
		end
		$display("test blocked done");
		bus(1, `LSI_OFF_BEAMS, 0);
		cyc(4);
		chk(safe, 1);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_RUN) | LAT | SCN);
		cyc(8);
		chk(rdisp, SEG[2]);
		// scan code stays up for the whole scan count first
		cyc(40);
		chk(rdisp, `LSI_DISP_L);
		chk(safe, 1);
		bus(0, `LSI_OFF_IRQ, 0);
		chk(q[`LSI_IRQ_SCAN], 1);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_RUN) | LAT | SCN | CST);
		cyc(8);
		chk({gl, gr}, 2'b11);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_RUN) | LAT | SCN | DNB);
		cyc(8);
		chk({safe, rlamp, rst_lamp}, {2'b01, LSI_RED});
		bus(1, `LSI_OFF_CTRL, 32'(LSI_RUN) | LAT | SCN);
		bus(1, `LSI_OFF_BEAMS, 32'h0000_0006);
		cyc(4);
		chk({safe, rlamp, rst_lamp}, {2'b01, LSI_RED});
		chk(rdisp, SEG[2]);
		bus(0, `LSI_OFF_CTRL, 0);
		chk(q[2:0], 32'(LSI_LATCHED));
		bus(1, `LSI_OFF_BEAMS, 0);
		cyc(4);
		chk(safe, 0);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_LATCHED) | LAT | SCN);
		tally(64);
		chk(arise > 1, 1);
		chk(safe, 0);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_LATCHED) | LAT | SCN | RST);
		for (int i = 0; i < 50 && safe !== 1'b1; i++) cyc(1);
		chk(safe, 1);
		$display("test latch done");
		bus(1, `LSI_OFF_CTRL, 32'(LSI_TEST));
		se = 0;
		sr = 0;
		for (int i = 0; i < 16; i++) begin
			cyc(1);
			se = se | int'(est === LSI_GREEN);
			sr = sr | int'(est === LSI_OFF);
		end
		chk(se & sr, 1);
		chk(rst_lamp, LSI_RED);
		$display("test test_mode done");
		bus(1, `LSI_OFF_MASK, 32'h0000_0001);
		bus(1, `LSI_OFF_ERR, ERR);
		bus(1, `LSI_OFF_CTRL, 32'(LSI_LOCK));
		se = 0;
		sr = 0;
		for (int i = 0; i < 64; i++) begin
			cyc(1);
			se = se | int'(edisp === ERR[7:0]);
			sr = sr | int'(rdisp === ERR[7:0]);
		end
		chk(se, 1);
		chk(sr, 1);
		chk({safe, rlamp, irq}, 3'b001);
		zones(0, 1);
		bus(1, `LSI_OFF_IRQ, 32'h0000_0001);
		cyc(4);
		chk(irq, 0);
		bus(1, 32'h0000_0040, 32'hffff_ffff);
		bus(0, 32'h0000_0040, 0);
		chk(q, 0);
		chk({hrdy, hresp}, 2'b10);
		$display("test lockout done");
		finish_test();
	end
endmodule
